// ===== hdl/irq_bank_defs.svh
/*
 * Offsets, field positions, masks and reset values of the peripheral
 * interrupt enable and request bank.
 * Assumes a 32-bit AXI4-Lite bus with byte addresses.
 */
`ifndef IRQ_BANK_DEFS_SVH
`define IRQ_BANK_DEFS_SVH

`define OFS_CORE_CTRL 8'h00
`define OFS_ENABLE_ONE 8'h04
`define OFS_ENABLE_TWO 8'h08
`define OFS_PWM_ENABLE 8'h0C
`define OFS_REQUEST_ONE 8'h10
`define OFS_REQUEST_TWO 8'h14
`define OFS_PWM_REQUEST 8'h18
`define OFS_BANK_STATUS 8'h1C
`define OFS_BANK_CLEAR 8'h20
`define OFS_BANK_ENABLE 8'h24

`define BIT_GLOBAL_EN 7
`define BIT_GROUP_EN 6
`define CTRL_MASK 8'hC0
`define ONE_MASK 8'hF3
`define ONE_WR_MASK 8'hD3
`define SERIAL_MASK 8'h30
`define BIT_SERIAL_RX 5
`define TWO_MASK 8'h20
`define PWM_MASK 8'h70
`define BANK_MASK 8'h07
`define REG_RESET 8'h00

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== hdl/irq_bank_pkg.sv
/*
 * Types for the peripheral interrupt bank: event bundle and the
 * AXI4-Lite channel groups.
 * Assumes the defs header is compiled alongside.
 */
package irq_bank_pkg;

    typedef struct packed {
        logic timer1Gate;      // Gate acquisition done, pulse
        logic converterDone;   // Conversion done, pulse
        logic serialRx;        // Receiver holds data, level
        logic serialTx;        // Transmitter ready, pulse
        logic timer2Match;     // Period match, pulse
        logic timer1Overflow;  // Overflow, pulse
        logic comparator;      // Comparator edge, pulse
    } periph_events_type;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
    } axi_wr_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
    } axi_wr_rsp_type;

    typedef struct packed {
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } axi_rd_req_type;

    typedef struct packed {
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axi_rd_rsp_type;

endpackage : irq_bank_pkg

// ===== hdl/peripheral_irq_flag_enable_bank.sv
/*
 * Peripheral interrupt enable and request bank with AXI4-Lite access,
 * core interrupt gating and a sticky bank interrupt.
 * Assumes event pulses and PWM flag levels come from mclk logic.
 */
`timescale 1ns/1ps
`include "irq_bank_defs.svh"

module peripheral_irq_flag_enable_bank #(
    parameter bit serialPresent = 1'b1
) (
    input wire logic mclk,                                   // 200 MHz clock
    input wire logic rst,                                    // Sync reset
    input wire irq_bank_pkg::axi_wr_req_type wrReq,          // Write request
    output irq_bank_pkg::axi_wr_rsp_type wrRsp,              // Write answer
    input wire irq_bank_pkg::axi_rd_req_type rdReq,          // Read request
    output irq_bank_pkg::axi_rd_rsp_type rdRsp,              // Read answer
    input wire irq_bank_pkg::periph_events_type events,      // Event sources
    input wire logic [2:0] pwmPending,                       // PWM flags ch3..1
    output logic coreIrq,                                    // To the core
    output logic bankIrq                                     // Bank status irq
);
    import irq_bank_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register state

    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] enOne_reg, enOne_next;
    logic [7:0] enTwo_reg, enTwo_next;
    logic [7:0] pwmEn_reg, pwmEn_next;
    logic [7:0] reqOne_reg, reqOne_next;
    logic [7:0] reqTwo_reg, reqTwo_next;
    logic [7:0] pwmReq_reg, pwmReq_next;
    logic [7:0] stat_reg, stat_next;
    logic [7:0] statEn_reg, statEn_next;

    // Write channel holding
    logic awHeld_reg, awHeld_next;
    logic wHeld_reg, wHeld_next;
    logic [7:0] awAddr_reg, awAddr_next;
    logic [31:0] wData_reg, wData_next;
    logic [3:0] wStrb_reg, wStrb_next;
    logic bValid_reg, bValid_next;
    logic [1:0] bResp_reg, bResp_next;

    // Read channel
    logic rValid_reg, rValid_next;
    logic [31:0] rData_reg, rData_next;
    logic [1:0] rResp_reg, rResp_next;

    logic writeFire;
    logic lowLane;
    logic [7:0] wByte;
    logic [7:0] oneImpl;
    logic [7:0] oneSet;
    logic [7:0] twoSet;
    logic [7:0] pwmIn;
    logic [7:0] newEvents;
    logic [7:0] rdByte;
    logic rdHit;
    logic wrHit;
    logic periphAny;

    ////////////////////////////////////////////////////////////////////////////
    // AXI handshakes

    assign wrRsp.awready = !awHeld_reg && !bValid_reg;
    assign wrRsp.wready = !wHeld_reg && !bValid_reg;
    assign wrRsp.bvalid = bValid_reg;
    assign wrRsp.bresp = bResp_reg;
    assign rdRsp.arready = !rValid_reg;
    assign rdRsp.rvalid = rValid_reg;
    assign rdRsp.rdata = rData_reg;
    assign rdRsp.rresp = rResp_reg;

    // Address and data may arrive in either order; the write lands once both are held
    assign writeFire = awHeld_reg && wHeld_reg && !bValid_reg;
    assign lowLane = writeFire && wStrb_reg[0];
    assign wByte = wData_reg[7:0];

    always_comb begin
        wrHit = 1'b1;
        case (awAddr_reg)
            `OFS_CORE_CTRL, `OFS_ENABLE_ONE, `OFS_ENABLE_TWO,
            `OFS_PWM_ENABLE, `OFS_REQUEST_ONE, `OFS_REQUEST_TWO,
            `OFS_PWM_REQUEST, `OFS_BANK_STATUS, `OFS_BANK_CLEAR,
            `OFS_BANK_ENABLE: wrHit = 1'b1;
            default: wrHit = 1'b0;
        endcase
    end

    always_comb begin
        awHeld_next = awHeld_reg;
        wHeld_next = wHeld_reg;
        awAddr_next = awAddr_reg;
        wData_next = wData_reg;
        wStrb_next = wStrb_reg;
        bValid_next = bValid_reg;
        bResp_next = bResp_reg;
        if (wrReq.awvalid && wrRsp.awready) begin
            awHeld_next = 1'b1;
            awAddr_next = {wrReq.awaddr[7:2], 2'h0};
        end
        if (wrReq.wvalid && wrRsp.wready) begin
            wHeld_next = 1'b1;
            wData_next = wrReq.wdata;
            wStrb_next = wrReq.wstrb;
        end
        if (writeFire) begin
            awHeld_next = 1'b0;
            wHeld_next = 1'b0;
            bValid_next = 1'b1;
            bResp_next = wrHit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bValid_reg && wrReq.bready) begin
            bValid_next = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= 8'h00;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
            bValid_reg <= 1'b0;
            bResp_reg <= `RESP_OKAY;
        end else begin
            awHeld_reg <= awHeld_next;
            wHeld_reg <= wHeld_next;
            awAddr_reg <= awAddr_next;
            wData_reg <= wData_next;
            wStrb_reg <= wStrb_next;
            bValid_reg <= bValid_next;
            bResp_reg <= bResp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags and enables

    // Serial bits vanish on the variant without the serial port
    assign oneImpl = serialPresent ? `ONE_MASK : (`ONE_MASK & ~`SERIAL_MASK);
    assign oneSet = {events.timer1Gate, events.converterDone, 1'b0,
                     events.serialTx, 2'h0, events.timer2Match,
                     events.timer1Overflow};
    assign twoSet = {2'h0, events.comparator, 5'h00};
    assign pwmIn = {1'b0, pwmPending, 4'h0};

    always_comb begin
        ctrl_next = ctrl_reg;
        enOne_next = enOne_reg;
        enTwo_next = enTwo_reg;
        pwmEn_next = pwmEn_reg;
        reqOne_next = reqOne_reg;
        reqTwo_next = reqTwo_reg;
        statEn_next = statEn_reg;
        if (lowLane) begin
            case (awAddr_reg)
                `OFS_CORE_CTRL: ctrl_next = wByte & `CTRL_MASK;
                `OFS_ENABLE_ONE: enOne_next = wByte & oneImpl;
                `OFS_ENABLE_TWO: enTwo_next = wByte & `TWO_MASK;
                `OFS_PWM_ENABLE: pwmEn_next = wByte & `PWM_MASK;
                `OFS_REQUEST_ONE: reqOne_next = (reqOne_reg & ~`ONE_WR_MASK)
                                                | (wByte & `ONE_WR_MASK);
                `OFS_REQUEST_TWO: reqTwo_next = wByte & `TWO_MASK;
                `OFS_BANK_ENABLE: statEn_next = wByte & `BANK_MASK;
                default: ;
            endcase
        end
        // Event set wins over a software clear in the same cycle
        reqOne_next = reqOne_next | oneSet;
        reqOne_next[`BIT_SERIAL_RX] = events.serialRx;
        reqOne_next = reqOne_next & oneImpl;
        reqTwo_next = (reqTwo_next | twoSet) & `TWO_MASK;
        // Mirror only; writes never reach these flags
        pwmReq_next = pwmIn & `PWM_MASK;
    end

    // Bank status: bit 0 request one, bit 1 request two, bit 2 PWM gained a flag
    assign newEvents = {5'h00,
                        |(pwmReq_next & ~pwmReq_reg),
                        |(reqTwo_next & ~reqTwo_reg),
                        |(reqOne_next & ~reqOne_reg)};

    always_comb begin
        stat_next = stat_reg;
        if (lowLane && awAddr_reg == `OFS_BANK_CLEAR) begin
            stat_next = stat_reg & ~wByte;
        end
        stat_next = (stat_next | newEvents) & `BANK_MASK;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_reg <= `REG_RESET;
            enOne_reg <= `REG_RESET;
            enTwo_reg <= `REG_RESET;
            pwmEn_reg <= `REG_RESET;
            reqOne_reg <= `REG_RESET;
            reqTwo_reg <= `REG_RESET;
            pwmReq_reg <= `REG_RESET;
            stat_reg <= `REG_RESET;
            statEn_reg <= `REG_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            enOne_reg <= enOne_next;
            enTwo_reg <= enTwo_next;
            pwmEn_reg <= pwmEn_next;
            reqOne_reg <= reqOne_next;
            reqTwo_reg <= reqTwo_next;
            pwmReq_reg <= pwmReq_next;
            stat_reg <= stat_next;
            statEn_reg <= statEn_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt outputs

    assign periphAny = |(reqOne_reg & enOne_reg) | |(reqTwo_reg & enTwo_reg)
                       | |(pwmReq_reg & pwmEn_reg);
    // Group then global gate; a stale flag fires at once when enabled
    assign coreIrq = ctrl_reg[`BIT_GLOBAL_EN] && ctrl_reg[`BIT_GROUP_EN]
                     && periphAny;
    assign bankIrq = |(stat_reg & statEn_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Read channel

    always_comb begin
        rdHit = 1'b1;
        case ({rdReq.araddr[7:2], 2'h0})
            `OFS_CORE_CTRL: rdByte = ctrl_reg;
            `OFS_ENABLE_ONE: rdByte = enOne_reg;
            `OFS_ENABLE_TWO: rdByte = enTwo_reg;
            `OFS_PWM_ENABLE: rdByte = pwmEn_reg;
            `OFS_REQUEST_ONE: rdByte = reqOne_reg;
            `OFS_REQUEST_TWO: rdByte = reqTwo_reg;
            `OFS_PWM_REQUEST: rdByte = pwmReq_reg;
            `OFS_BANK_STATUS: rdByte = stat_reg;
            `OFS_BANK_CLEAR: rdByte = 8'h00;
            `OFS_BANK_ENABLE: rdByte = statEn_reg;
            default: begin
                rdByte = 8'h00;
                rdHit = 1'b0;
            end
        endcase
    end

    always_comb begin
        rValid_next = rValid_reg;
        rData_next = rData_reg;
        rResp_next = rResp_reg;
        if (rdReq.arvalid && rdRsp.arready) begin
            rValid_next = 1'b1;
            rData_next = {24'h00_0000, rdByte};
            rResp_next = rdHit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rValid_reg && rdReq.rready) begin
            rValid_next = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rValid_reg <= 1'b0;
            rData_reg <= 32'h0000_0000;
            rResp_reg <= `RESP_OKAY;
        end else begin
            rValid_reg <= rValid_next;
            rData_reg <= rData_next;
            rResp_reg <= rResp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_group_gate: assert property (coreIrq |-> ctrl_reg[`BIT_GROUP_EN])
        else $error("core irq without group enable");
    a_global_gate: assert property (!ctrl_reg[`BIT_GLOBAL_EN] |-> !coreIrq)
        else $error("core irq while global enable clear");
    a_gate_flag_set: assert property (events.timer1Gate |=> reqOne_reg[7])
        else $error("timer1 gate flag not set");
    a_adc_flag_set: assert property (events.converterDone |=> reqOne_reg[6])
        else $error("converter flag not set");
    a_rx_mirror: assert property (##1 reqOne_reg[5] == ($past(events.serialRx) && serialPresent))
        else $error("receive flag does not follow source");
    a_tx_flag_set: assert property (events.serialTx && serialPresent |=> reqOne_reg[4])
        else $error("transmit flag not set");
    a_t2_flag_set: assert property (events.timer2Match |=> reqOne_reg[1])
        else $error("timer2 flag not set");
    a_ovf_flag_set: assert property (events.timer1Overflow |=> reqOne_reg[0])
        else $error("overflow flag not set");
    a_cmp_flag_set: assert property (events.comparator |=> reqTwo_reg[5])
        else $error("comparator flag not set");
    a_pwm_mirror: assert property (##1 pwmReq_reg[6:4] == $past(pwmPending))
        else $error("pwm flags do not follow source");
    a_pwm_no_write: assert property (lowLane && awAddr_reg == `OFS_PWM_REQUEST
        && pwmPending == 3'h0 |=> pwmReq_reg == 8'h00)
        else $error("pwm flags took a write");
    a_set_beats_off: assert property (events.timer1Overflow && !ctrl_reg[`BIT_GLOBAL_EN]
        |=> reqOne_reg[0])
        else $error("flag lost while disabled");
    a_unimpl_zero: assert property (reqOne_reg[3:2] == 2'h0 && reqTwo_reg[4:0] == 5'h00
        && pwmEn_reg[3:0] == 4'h0 && enTwo_reg[7:6] == 2'h0)
        else $error("unimplemented bit set");
    a_reset_clear: assert property ($past(rst) |-> reqOne_reg == 8'h00 && enOne_reg == 8'h00
        && ctrl_reg == 8'h00 && pwmEn_reg == 8'h00)
        else $error("register not zero after reset");
    a_pwm_en_write: assert property (lowLane && awAddr_reg == `OFS_PWM_ENABLE
        |=> pwmEn_reg[6:4] == $past(wByte[6:4]))
        else $error("pwm enable write lost");
    a_en_one_write: assert property (lowLane && awAddr_reg == `OFS_ENABLE_ONE
        |=> enOne_reg[7:6] == $past(wByte[7:6]) && enOne_reg[1:0] == $past(wByte[1:0]))
        else $error("enable one write lost");
    a_en_two_write: assert property (lowLane && awAddr_reg == `OFS_ENABLE_TWO
        |=> enTwo_reg[5] == $past(wByte[5]))
        else $error("enable two write lost");
    a_core_request: assert property (ctrl_reg[7:6] == 2'h3 && reqTwo_reg[5] && enTwo_reg[5]
        |-> coreIrq)
        else $error("core irq missing");
    a_write_answer: assert property (writeFire |=> wrRsp.bvalid [*1] ##0 !wrRsp.awready)
        else $error("write answer missing");
    a_ctrl_unimpl: assert property (ctrl_reg[5:0] == 6'h00)
        else $error("control spare bit set");
    a_one_unimpl: assert property ((enOne_reg & ~oneImpl) == 8'h00)
        else $error("enable one spare bit set");
    a_pwm_unimpl: assert property (pwmReq_reg[7] == 1'b0 && pwmReq_reg[3:0] == 4'h0)
        else $error("pwm request spare bit set");
    a_serial_absent: assert property (serialPresent || reqOne_reg[5:4] == 2'h0)
        else $error("serial flag without serial port");
    a_wr_clear: assert property (lowLane && awAddr_reg == `OFS_REQUEST_ONE && wByte == 8'h00
        && oneSet == 8'h00 |=> (reqOne_reg & `ONE_WR_MASK) == 8'h00)
        else $error("flag write of zero not taken");
    a_one_writable: assert property (lowLane && awAddr_reg == `OFS_REQUEST_ONE
        |=> &(reqOne_reg | ~($past(wByte) & `ONE_WR_MASK & oneImpl)))
        else $error("flag write of one not taken");
    a_two_write: assert property (lowLane && awAddr_reg == `OFS_REQUEST_TWO
        |=> reqTwo_reg[5] == ($past(wByte[5]) || $past(events.comparator)))
        else $error("request two write wrong");
    a_core_one: assert property (ctrl_reg[7:6] == 2'h3 && |(reqOne_reg & enOne_reg) |-> coreIrq)
        else $error("core irq missing for request one");
    a_core_pwm: assert property (ctrl_reg[7:6] == 2'h3 && |(pwmReq_reg & pwmEn_reg) |-> coreIrq)
        else $error("core irq missing for pwm");
    a_read_answer: assert property (rdReq.arvalid && rdRsp.arready |=> rdRsp.rvalid)
        else $error("read answer missing");
    a_stat_sticky: assert property (stat_reg[0] && !(lowLane && awAddr_reg == `OFS_BANK_CLEAR)
        |=> stat_reg[0])
        else $error("bank status bit lost");
    a_reset_rest: assert property ($past(rst) |-> enTwo_reg == 8'h00 && reqTwo_reg == 8'h00
        && pwmReq_reg == 8'h00 && stat_reg == 8'h00 && statEn_reg == 8'h00)
        else $error("second group not zero after reset");
    // Writable flags hold between writes; only events add to them
    a_flag_sticky: assert property (!lowLane |=> (reqOne_reg & `ONE_WR_MASK)
        == (($past(reqOne_reg) | $past(oneSet)) & `ONE_WR_MASK & oneImpl))
        else $error("writable flag changed without write");

    c_core_irq: cover property (!coreIrq ##1 coreIrq);
    c_pwm_flag: cover property (pwmReq_reg[6] && pwmEn_reg[6]);
    c_set_and_clear: cover property (lowLane && awAddr_reg == `OFS_REQUEST_ONE && events.timer1Overflow);
    c_bank_irq: cover property (bankIrq);
    c_pwm_write_ignored: cover property (lowLane && awAddr_reg == `OFS_PWM_REQUEST && pwmPending != 3'h0);

endmodule : peripheral_irq_flag_enable_bank

// ===== verif/event_source_model.sv
/*
 * Model of the on-chip peripherals that raise events and hold PWM flags.
 * Assumes the bench calls its tasks just after a rising edge of mclk.
 */
`timescale 1ns/1ps
module event_source_model (
    input wire logic mclk,                             // Clock
    output irq_bank_pkg::periph_events_type events,    // Event bundle
    output logic [2:0] pwmPending                      // PWM flag levels ch3..1
);
    import irq_bank_pkg::*;
    logic [6:0] rxBits;
    logic [6:0] pulseBits;

    initial begin
        pulseBits = 7'h00;
        pwmPending = 3'h0;
        rxBits = 7'h00;
    end

    // Pulses and the receive level are kept apart so both may change in one step
    assign events = periph_events_type'(pulseBits | rxBits);

    // Set pulses last one edge
    task automatic pulse(input logic [6:0] e);
        pulseBits <= e;
        @(posedge mclk);
        pulseBits <= 7'h00;
    endtask : pulse

    // A receiver holds its flag as long as data waits
    task automatic set_rx(input logic level);
        rxBits <= {2'h0, level, 4'h0};
    endtask : set_rx

    // Flags live in the PWM module; only it clears them
    task automatic set_pwm(input logic [2:0] p);
        pwmPending <= p;
    endtask : set_pwm
endmodule : event_source_model

// ===== verif/testbench.sv
/*
 * Self-checking bench for the peripheral interrupt bank over AXI4-Lite.
 * Assumes the defs header and the package are compiled first.
 */
`timescale 1ns/1ps
`include "irq_bank_defs.svh"
module testbench;
    import irq_bank_pkg::*;
    logic mclk;
    logic rst;
    axi_wr_req_type wrReq;
    axi_wr_rsp_type wrRsp;
    axi_rd_req_type rdReq;
    axi_rd_rsp_type rdRsp;
    periph_events_type events;
    logic [2:0] pwmPending;
    logic coreIrq;
    logic bankIrq;
    int nMismatch;
    int comparisons;
    logic [7:0] enAddr [4] = '{`OFS_CORE_CTRL, `OFS_ENABLE_ONE, `OFS_ENABLE_TWO, `OFS_PWM_ENABLE};
    logic [7:0] enMask [4] = '{8'hC0, 8'hF3, 8'h20, 8'h70};
    logic [7:0] ctlVal [4] = '{8'h00, 8'h40, 8'h80, 8'hC0};

    peripheral_irq_flag_enable_bank #(.serialPresent(1'b1)) peripheral_irq_flag_enable_bank_i (
        .mclk(mclk), .rst(rst), .wrReq(wrReq), .wrRsp(wrRsp), .rdReq(rdReq), .rdRsp(rdRsp),
        .events(events), .pwmPending(pwmPending), .coreIrq(coreIrq), .bankIrq(bankIrq));
    event_source_model event_source_model_i (.mclk(mclk), .events(events), .pwmPending(pwmPending));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, nMismatch);
        if (nMismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            nMismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            nMismatch++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic stall_out(input string what);
        nMismatch++;
        $display("ERROR %s expected answer seen none", what);
        give_verdict();
    endtask : stall_out

    ////////////////////////////////////////////////////////////////////////////
    task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] strb,
                             input logic [1:0] expResp);
        bit done;
        done = 1'b0;
        @(posedge mclk);
        wrReq.awaddr <= a;
        wrReq.awvalid <= 1'b1;
        // Upper lanes carry copies that the bank must ignore
        wrReq.wdata <= {d, d, d, d};
        wrReq.wstrb <= strb;
        wrReq.wvalid <= 1'b1;
        wrReq.bready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge mclk);
            if (wrReq.awvalid && wrRsp.awready === 1'b1) wrReq.awvalid <= 1'b0;
            if (wrReq.wvalid && wrRsp.wready === 1'b1) wrReq.wvalid <= 1'b0;
            if (wrRsp.bvalid === 1'b1) begin
                check_word($sformatf("bresp@%h", a), {30'h0, expResp}, {30'h0, wrRsp.bresp});
                wrReq.bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) stall_out("write");
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [7:0] expData, input logic [1:0] expResp);
        bit done;
        done = 1'b0;
        @(posedge mclk);
        rdReq.araddr <= a;
        rdReq.arvalid <= 1'b1;
        rdReq.rready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge mclk);
            if (rdReq.arvalid && rdRsp.arready === 1'b1) rdReq.arvalid <= 1'b0;
            if (rdRsp.rvalid === 1'b1) begin
                check_word($sformatf("rresp@%h", a), {30'h0, expResp}, {30'h0, rdRsp.rresp});
                if (expResp == `RESP_OKAY) check_word($sformatf("rdata@%h", a), {24'h0, expData}, rdRsp.rdata);
                rdReq.rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) stall_out("read");
    endtask : axi_read

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        axi_write(a, d, 4'hF, `RESP_OKAY);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] expData);
        axi_read(a, expData, `RESP_OKAY);
    endtask : rd

    // Outputs are combinational from registers, so look once settled
    task automatic irq_check(input logic expCore, input logic expBank);
        @(posedge mclk);
        #1;
        check_bit("coreIrq", expCore, coreIrq);
        check_bit("bankIrq", expBank, bankIrq);
    endtask : irq_check

    task automatic do_reset;
        rst <= 1'b1;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        wrReq = '0;
        rdReq = '0;
        nMismatch = 0;
        comparisons = 0;
        do_reset();
        for (int i = 0; i < 10; i++) rd(8'(4 * i), 8'h00);
        irq_check(1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            wr(enAddr[i], 8'hFF);
            rd(enAddr[i], enMask[i]);
        end
        // Lane 0 strobe off: answered, lands nowhere
        axi_write(`OFS_ENABLE_TWO, 8'h00, 4'hE, `RESP_OKAY);
        rd(`OFS_ENABLE_TWO, 8'h20);
        // Address bits 1:0 are ignored on both channels
        wr(8'h0F, 8'h00);
        rd(8'h0D, 8'h00);
        // Writable flags take software values; receive and PWM flags do not
        wr(`OFS_REQUEST_ONE, 8'hFF);
        rd(`OFS_REQUEST_ONE, 8'hD3);
        irq_check(1'b1, 1'b0);
        wr(`OFS_REQUEST_ONE, 8'h00);
        rd(`OFS_REQUEST_ONE, 8'h00);
        wr(`OFS_REQUEST_TWO, 8'hFF);
        rd(`OFS_REQUEST_TWO, 8'h20);
        wr(`OFS_REQUEST_TWO, 8'h00);
        wr(`OFS_PWM_REQUEST, 8'hFF);
        rd(`OFS_PWM_REQUEST, 8'h00);
        for (int i = 0; i < 4; i++) wr(enAddr[i], 8'h00);
        // Events land with every enable off
        event_source_model_i.set_rx(1'b1);
        event_source_model_i.set_pwm(3'h7);
        event_source_model_i.pulse(7'b1101111);
        rd(`OFS_REQUEST_ONE, 8'hF3);
        rd(`OFS_REQUEST_TWO, 8'h20);
        rd(`OFS_PWM_REQUEST, 8'h70);
        irq_check(1'b0, 1'b0);
        wr(`OFS_PWM_REQUEST, 8'h00);
        rd(`OFS_PWM_REQUEST, 8'h70);
        wr(`OFS_REQUEST_ONE, 8'h00);
        rd(`OFS_REQUEST_ONE, 8'h20);
        event_source_model_i.set_rx(1'b0);
        event_source_model_i.set_pwm(3'h0);
        rd(`OFS_PWM_REQUEST, 8'h00);
        wr(`OFS_REQUEST_TWO, 8'h00);
        // An event in the cycle of a software clear wins
        fork
            wr(`OFS_REQUEST_ONE, 8'h00);
            begin
                repeat (2) @(posedge mclk);
                event_source_model_i.pulse(7'b0000010);
            end
        join
        rd(`OFS_REQUEST_ONE, 8'h01);
        // Gating by group and global enables
        wr(`OFS_REQUEST_ONE, 8'h00);
        wr(`OFS_ENABLE_ONE, 8'h01);
        event_source_model_i.pulse(7'b0000010);
        for (int i = 0; i < 4; i++) begin
            wr(`OFS_CORE_CTRL, ctlVal[i]);
            irq_check(ctlVal[i] == 8'hC0, 1'b0);
        end
        wr(`OFS_REQUEST_ONE, 8'h00);
        irq_check(1'b0, 1'b0);
        wr(`OFS_ENABLE_ONE, 8'h00);
        wr(`OFS_PWM_ENABLE, 8'h40);
        event_source_model_i.set_pwm(3'b010);
        irq_check(1'b0, 1'b0);
        event_source_model_i.set_pwm(3'b100);
        irq_check(1'b1, 1'b0);
        event_source_model_i.set_pwm(3'h0);
        wr(`OFS_PWM_ENABLE, 8'h00);
        wr(`OFS_REQUEST_TWO, 8'h00);
        wr(`OFS_ENABLE_TWO, 8'h20);
        event_source_model_i.pulse(7'b0000001);
        irq_check(1'b1, 1'b0);
        wr(`OFS_ENABLE_TWO, 8'h00);
        irq_check(1'b0, 1'b0);
        // Bank status: sticky, maskable, cleared by writing ones
        wr(`OFS_BANK_CLEAR, 8'h07);
        rd(`OFS_BANK_STATUS, 8'h00);
        wr(`OFS_BANK_ENABLE, 8'h07);
        rd(`OFS_BANK_ENABLE, 8'h07);
        event_source_model_i.pulse(7'b0100000);
        rd(`OFS_BANK_STATUS, 8'h01);
        irq_check(1'b0, 1'b1);
        wr(`OFS_BANK_ENABLE, 8'h00);
        irq_check(1'b0, 1'b0);
        wr(`OFS_BANK_STATUS, 8'h00);
        rd(`OFS_BANK_STATUS, 8'h01);
        rd(`OFS_BANK_CLEAR, 8'h00);
        wr(`OFS_BANK_CLEAR, 8'h01);
        rd(`OFS_BANK_STATUS, 8'h00);
        // Unmapped place answers with an error
        axi_write(8'h40, 8'hFF, 4'hF, `RESP_SLVERR);
        axi_read(8'h40, 8'h00, `RESP_SLVERR);
        // Reset in mid-run clears everything again
        for (int i = 0; i < 4; i++) wr(enAddr[i], 8'hFF);
        wr(`OFS_REQUEST_ONE, 8'hFF);
        do_reset();
        for (int i = 0; i < 4; i++) rd(enAddr[i], 8'h00);
        rd(`OFS_REQUEST_ONE, 8'h00);
        irq_check(1'b0, 1'b0);
        give_verdict();
    end
endmodule : testbench
